// ===== tmg_pkg.sv
package tmg_pkg;
    // Register addresses on the plain register port.
    localparam logic [2:0] ADDR_CLK_CFG = 3'h0;
    localparam logic [2:0] ADDR_MODE    = 3'h1;
    localparam logic [2:0] ADDR_CTL     = 3'h2;
    localparam logic [2:0] ADDR_DATA    = 3'h3;
    localparam logic [2:0] ADDR_FLAGS   = 3'h4;
    localparam logic [2:0] ADDR_IRQ_EN  = 3'h5;
    // Field positions.
    localparam int DEBUG_RUN_BIT = 8;
    localparam int DIV_LSB    = 4;
    localparam int TIME_LSB   = 8;
    localparam int DRIVE_BIT  = 2;
    localparam int STOP_BIT   = 8;
    localparam int TIE_BIT    = 15;
    localparam int REST_BIT   = 14;
    localparam int LEN_LSB    = 8;
    localparam int BUSY_BIT   = 8;
    localparam int EMPTY_BIT  = 1;
    localparam int DONE_BIT   = 0;
    // Values after reset.
    localparam logic [15:0] DATA_RESET  = 16'h00ff;
    localparam logic        EMPTY_RESET = 1'b1;
    // Clock source, divider and mode codes.
    localparam logic [1:0] SRC_INT  = 2'h0;
    localparam logic [1:0] SRC_LOW  = 2'h1;
    localparam logic [1:0] SRC_HIGH = 2'h2;
    localparam logic [1:0] SRC_EXT  = 2'h3;
    localparam logic [2:0] DIV_MAX    = 3'h5;
    localparam logic [2:0] DIV_BYPASS = 3'h7;
    localparam logic [1:0] MODE_NORMAL  = 2'h0;
    localparam logic [1:0] MODE_ONESHOT = 2'h1;
    localparam logic [1:0] MODE_MELODY  = 2'h2;
    // Timing on the operating clock.
    localparam longint OP_CLK_HZ    = 32768;
    localparam longint STEP_TIME_NS = 15625000;
    localparam int STEP_TICKS = int'((OP_CLK_HZ * STEP_TIME_NS) / 64'd1000000000);
    localparam logic [8:0] STEP_LAST = 9'(STEP_TICKS - 1);
    localparam logic [8:0] GAP_TICKS = 9'h040;
    typedef enum logic {TMG_IDLE = 1'b0, TMG_PLAY = 1'b1} tmg_state_e;
endpackage

// ===== tmg_core.sv
`timescale 1ns/1ps
// Function
// R1: Debug-run bit 1 keeps the operating clock during debug; 0 withholds it.
// R2: Clock source field picks internal, low-speed, high-speed or external clock.
// R3: Fast sources divide by 4 to 128; slow sources pass undivided at code 7.
// R4: Software changes clock configuration only while the module is disabled.
// R5: Melody tempo is 480 divided by code plus one quarter notes per minute.
// R6: One-shot duration is code plus one steps of about 15.6 ms.
// R7: Software leaves the time field alone while output is busy.
// R8: Drive mode bit selects normal drive at 1 and direct drive at 0.
// R9: Output mode field selects normal, one-shot or melody; code 3 is reserved.
// R10: Stop write starts stopping, reads 1 until output completes, 0 ignored.
// R11: Stop write forcibly ends one-shot and melody output too.
// R12: Module enable supplies the operating clock; clearing it stops the clock.
// R13: Writing the sound buffer starts output with the written fields.
// R14: Only full 16-bit buffer writes count; byte writes are discarded.
// R15: In melody mode the tie bit joins the note to the previous one.
// R16: A melody rest holds the buzzer low and its inverse high.
// R17: Length field gives note duration in melody, duty ratio in buzzer modes.
// R18: Pitch field gives scale in melody; buzzer modes use its low six bits.
// R19: Pitch field resets to all ones, other buffer fields to zero.
// R20: Buffer-empty flag resets to 1, is read-only, cleared by buffer write.
// R21: Done flag cleared by writing 1 or buffer write; busy resets to 0.
// R22: Buffer-empty sets when data moves to the active note or on stop.
// R23: Interrupt request rises only for a set flag with its enable set.
// R24: Busy reads 1 while sound is output and 0 when idle.
// R25: Reserved bits read as zero and ignore writes.
module tmg_core
    import tmg_pkg::*;
(
    input  wire logic        clk_in,
    input  wire logic        rst_n_in,
    input  wire logic [2:0]  addr_in,
    input  wire logic [15:0] wdata_in,
    input  wire logic        wr_in,
    input  wire logic        wr_full_in,
    input  wire logic        rd_in,
    output logic      [15:0] rdata_out,
    input  wire logic        debug_mode_in,
    input  wire logic        int_osc_tick_in,
    input  wire logic        low_osc_tick_in,
    input  wire logic        high_osc_tick_in,
    input  wire logic        ext_clk_in,
    output logic             buzzer_out,
    output logic             buzzer_out_inverted_out,
    output logic             irq_out
);
    function automatic logic [10:0] note_steps(input logic [1:0] mode, input logic [3:0] tim,
                                               input logic [5:0] len);
        if (mode == MODE_MELODY)
            note_steps = (11'(tim) + 11'd1) * (11'(len) + 11'd1);
        else
            note_steps = 11'(tim) + 11'd1;
    endfunction

    function automatic logic wave_high(input logic mel, input logic [7:0] ph, input logic [8:0] per,
                                       input logic [5:0] len);
        if (mel)
            wave_high = {ph, 1'b0} < per;
        else
            wave_high = {1'b0, ph, 6'h00} < (15'(len) + 15'd1) * 15'(per);
    endfunction

    logic        debug_run_q, enable_q, drive_q, stop_q, empty_q, done_q, buf_full_q;
    logic        empty_ie_q, done_ie_q;
    logic [2:0]  div_q;
    logic [1:0]  src_q, mode_q;
    logic [3:0]  time_unit_q;
    logic [15:0] buf_q;
    logic        act_tie_q, act_rest_q;
    logic [5:0]  act_len_q;
    logic [7:0]  act_pitch_q;
    logic [6:0]  div_cnt_q;
    logic [8:0]  tick_q;
    logic [10:0] step_q;
    logic [7:0]  phase_q;
    logic        ext_s1_q, ext_s2_q, ext_s3_q;
    logic        buzz_q, inv_q, irq_q;
    logic [15:0] rdata_q;
    tmg_state_e  state_q;

    wire wr_clk   = wr_in && addr_in == ADDR_CLK_CFG;
    wire wr_mode  = wr_in && addr_in == ADDR_MODE;
    wire wr_ctl   = wr_in && addr_in == ADDR_CTL;
    wire wr_flags = wr_in && addr_in == ADDR_FLAGS;
    wire wr_ie    = wr_in && addr_in == ADDR_IRQ_EN;
    wire dat_wr   = wr_in && addr_in == ADDR_DATA && wr_full_in; // R13 R14
    wire stop_wr  = wr_ctl && wdata_in[STOP_BIT];                 // R10

    // Operating clock enable: source select, divider and gating.
    wire ext_rise = ext_s2_q && !ext_s3_q;
    wire src_tick = (src_q == SRC_INT)  ? int_osc_tick_in  :      // R2
                    (src_q == SRC_LOW)  ? low_osc_tick_in  :
                    (src_q == SRC_HIGH) ? high_osc_tick_in : ext_rise;
    wire run      = enable_q && (!debug_mode_in || debug_run_q);  // R1 R12
    wire fast_src = src_q == SRC_INT || src_q == SRC_HIGH;
    wire [6:0] div_mask = 7'((8'h04 << div_q) - 8'h01);
    wire div_hit  = fast_src ? (div_q <= DIV_MAX && (div_cnt_q & div_mask) == div_mask) // R3
                             : div_q == DIV_BYPASS;
    wire op_tick  = run && src_tick && div_hit;

    // Sequencing of the active note.
    wire playing  = state_q == TMG_PLAY;
    wire melody   = mode_q == MODE_MELODY;
    wire have_dat = buf_full_q || dat_wr;
    wire [15:0] load_src = dat_wr ? wdata_in : buf_q;
    wire [10:0] steps    = note_steps(mode_q, time_unit_q, act_len_q); // R5 R6 R17
    wire note_end = tick_q == STEP_LAST && step_q == steps - 11'd1;
    wire timed    = mode_q == MODE_ONESHOT || melody;
    wire do_stop  = op_tick && playing && stop_q;                 // R10 R11
    wire finish   = op_tick && playing && !stop_q && timed && note_end && !(melody && have_dat);
    wire out_end  = do_stop || finish;
    wire do_load  = op_tick && !stop_q && have_dat
                    && (!playing || mode_q == MODE_NORMAL || (melody && note_end)); // R13
    wire load_tie = melody && load_src[TIE_BIT];                  // R15
    wire [8:0] period = melody ? {1'b0, act_pitch_q} + 9'd1     // R18
                               : {3'b000, act_pitch_q[5:0]} + 9'd1;
    wire gap      = melody && !act_tie_q && step_q == 11'd0 && tick_q < GAP_TICKS; // R15
    wire rest_on  = melody && act_rest_q;                         // R16
    wire sound    = playing && !rest_on && !gap && wave_high(melody, phase_q, period, act_len_q); // R17
    wire inv_next = drive_q ? (playing && !sound) : (playing && rest_on); // R8 R16
    wire irq_cause = (empty_q && empty_ie_q) || (done_q && done_ie_q); // R23

    wire [15:0] rd_word =
        (addr_in == ADDR_CLK_CFG) ? {7'h00, debug_run_q, 1'b0, div_q, 2'b00, src_q} :  // R25
        (addr_in == ADDR_MODE)    ? {4'h0, time_unit_q, 5'h00, drive_q, mode_q} :
        (addr_in == ADDR_CTL)     ? {7'h00, stop_q, 7'h00, enable_q} :
        (addr_in == ADDR_DATA)    ? buf_q :
        (addr_in == ADDR_FLAGS)   ? {7'h00, playing, 6'h00, empty_q, done_q} :    // R24
        (addr_in == ADDR_IRQ_EN)  ? {14'h0000, empty_ie_q, done_ie_q} : 16'h0000;

    // The first stage feeds only the second; edge detection looks at later stages.
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            ext_s1_q <= 1'b0;
            ext_s2_q <= 1'b0;
            ext_s3_q <= 1'b0;
        end else begin
            ext_s1_q <= ext_clk_in;
            ext_s2_q <= ext_s1_q;
            ext_s3_q <= ext_s2_q;
        end
    end

    // Clock configuration is frozen while enabled so the divider never glitches.
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            debug_run_q <= 1'b0;
            div_q       <= 3'h0;
            src_q       <= SRC_INT;
        end else if (wr_clk && !enable_q) begin // R4
            debug_run_q <= wdata_in[DEBUG_RUN_BIT];
            div_q       <= wdata_in[DIV_LSB +: 3];
            src_q       <= wdata_in[1:0];
        end
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            time_unit_q <= 4'h0;
            drive_q     <= 1'b0;
            mode_q      <= MODE_NORMAL;
        end else if (wr_mode) begin // R9
            time_unit_q <= wdata_in[TIME_LSB +: 4];
            drive_q     <= wdata_in[DRIVE_BIT];
            mode_q      <= wdata_in[1:0];
        end
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            enable_q   <= 1'b0;
            empty_ie_q <= 1'b0;
            done_ie_q  <= 1'b0;
        end else begin
            if (wr_ctl)
                enable_q <= wdata_in[0]; // R12
            if (wr_ie) begin
                empty_ie_q <= wdata_in[EMPTY_BIT];
                done_ie_q  <= wdata_in[DONE_BIT];
            end
        end
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in)
            div_cnt_q <= 7'h00;
        else if (run && src_tick)
            div_cnt_q <= div_cnt_q + 7'h01;
    end

    // Stop completes at the next operating tick, whether or not sound was playing.
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in)
            stop_q <= 1'b0;
        else if (stop_wr)
            stop_q <= 1'b1;  // R10
        else if (op_tick)
            stop_q <= 1'b0;
    end

    // Set wins over clear for both flags.
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            buf_q      <= DATA_RESET; // R19
            buf_full_q <= 1'b0;
            empty_q    <= EMPTY_RESET;
            done_q     <= 1'b0;
        end else begin
            if (dat_wr)
                buf_q <= wdata_in;
            if (dat_wr && !do_load)
                buf_full_q <= 1'b1;
            else if (do_load || stop_wr)
                buf_full_q <= 1'b0;
            if (do_load || stop_wr)
                empty_q <= 1'b1; // R22
            else if (dat_wr)
                empty_q <= 1'b0; // R20
            if (out_end)
                done_q <= 1'b1;
            else if (dat_wr || (wr_flags && wdata_in[DONE_BIT]))
                done_q <= 1'b0; // R21
        end
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in)
            state_q <= TMG_IDLE;
        else if (out_end)
            state_q <= TMG_IDLE;
        else if (do_load)
            state_q <= TMG_PLAY; // R24
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            act_tie_q   <= 1'b0;
            act_rest_q  <= 1'b0;
            act_len_q   <= 6'h00;
            act_pitch_q <= 8'hff;
        end else if (do_load) begin
            act_tie_q   <= load_tie;
            act_rest_q  <= load_src[REST_BIT];
            act_len_q   <= load_src[LEN_LSB +: 6];
            act_pitch_q <= load_src[7:0];
        end
    end

    // A tied note keeps the waveform phase running so no click is heard.
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            tick_q  <= 9'h000;
            step_q  <= 11'h000;
            phase_q <= 8'h00;
        end else if (do_load) begin
            tick_q  <= 9'h000;
            step_q  <= 11'h000;
            if (!load_tie)
                phase_q <= 8'h00;
        end else if (op_tick && playing) begin
            tick_q  <= (tick_q == STEP_LAST) ? 9'h000 : tick_q + 9'h001;
            step_q  <= (tick_q == STEP_LAST) ? step_q + 11'h001 : step_q;
            phase_q <= ({1'b0, phase_q} >= period - 9'd1) ? 8'h00 : phase_q + 8'h01;
        end
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            buzz_q  <= 1'b0;
            inv_q   <= 1'b0;
            irq_q   <= 1'b0;
            rdata_q <= 16'h0000;
        end else begin
            buzz_q  <= sound;
            inv_q   <= inv_next;
            irq_q   <= irq_cause; // R23
            rdata_q <= rd_in ? rd_word : 16'h0000;
        end
    end

    assign buzzer_out              = buzz_q;
    assign buzzer_out_inverted_out = inv_q;
    assign irq_out                 = irq_q;
    assign rdata_out               = rdata_q;

    property p_enable_gates;
        @(posedge clk_in) disable iff (!rst_n_in) !enable_q |=> $stable(tick_q) && $stable(state_q);
    endproperty
    a_enable_gates: assert property (p_enable_gates) else $error("tick while disabled"); // R12

    property p_debug_gates;
        @(posedge clk_in) disable iff (!rst_n_in) debug_mode_in && !debug_run_q |=> $stable(tick_q) && $stable(state_q);
    endproperty
    a_debug_gates: assert property (p_debug_gates) else $error("tick in debug"); // R1

    property p_byte_write_dropped;
        @(posedge clk_in) disable iff (!rst_n_in)
            wr_in && addr_in == ADDR_DATA && !wr_full_in |=> buf_q == $past(buf_q);
    endproperty
    a_byte_write_dropped: assert property (p_byte_write_dropped) else $error("byte write taken"); // R14

    property p_write_clears_empty;
        @(posedge clk_in) disable iff (!rst_n_in)
            dat_wr && !do_load && !stop_wr && !out_end |=> !empty_q && buf_full_q && !done_q;
    endproperty
    a_write_clears_empty: assert property (p_write_clears_empty) else $error("write flags wrong"); // R20

    property p_rest_levels;
        @(posedge clk_in) disable iff (!rst_n_in) playing && rest_on |=> !buzz_q && inv_q;
    endproperty
    a_rest_levels: assert property (p_rest_levels) else $error("rest levels wrong"); // R16

    property p_stop_flags;
        @(posedge clk_in) disable iff (!rst_n_in) stop_wr |=> stop_q && empty_q;
    endproperty
    a_stop_flags: assert property (p_stop_flags) else $error("stop not taken"); // R10

    property p_stop_ends;
        @(posedge clk_in) disable iff (!rst_n_in) do_stop |=> !playing && done_q ##1 !playing;
    endproperty
    a_stop_ends: assert property (p_stop_ends) else $error("stop did not end"); // R11

    property p_done_clear;
        @(posedge clk_in) disable iff (!rst_n_in) wr_flags && wdata_in[DONE_BIT] && !out_end |=> !done_q;
    endproperty
    a_done_clear: assert property (p_done_clear) else $error("done not cleared"); // R21

    property p_busy_read;
        @(posedge clk_in) disable iff (!rst_n_in)
            rd_in && addr_in == ADDR_FLAGS |=> rdata_out[BUSY_BIT] == $past(playing);
    endproperty
    a_busy_read: assert property (p_busy_read) else $error("busy read wrong"); // R24

    property p_reserved_zero;
        @(posedge clk_in) disable iff (!rst_n_in)
            rd_in && addr_in == ADDR_CTL |=> rdata_out[15:9] == 7'h00 && rdata_out[7:1] == 7'h00;
    endproperty
    a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bits set"); // R25

    property p_irq;
        @(posedge clk_in) disable iff (!rst_n_in) irq_out |-> $past(irq_cause);
    endproperty
    a_irq: assert property (p_irq) else $error("irq without cause"); // R23

    property p_pins_exclusive;
        @(posedge clk_in) disable iff (!rst_n_in) !(buzz_q && inv_q);
    endproperty
    a_pins_exclusive: assert property (p_pins_exclusive) else $error("both pins high"); // R8

    property p_load_sets_empty;
        @(posedge clk_in) disable iff (!rst_n_in) do_load |=> empty_q && playing;
    endproperty
    a_load_sets_empty: assert property (p_load_sets_empty) else $error("load flags wrong"); // R22

    property p_stop_completes;
        @(posedge clk_in) disable iff (!rst_n_in) stop_q && op_tick && !stop_wr |=> !stop_q;
    endproperty
    a_stop_completes: assert property (p_stop_completes) else $error("stop stuck"); // R10

    property p_gap_silent;
        @(posedge clk_in) disable iff (!rst_n_in) gap |=> !buzz_q;
    endproperty
    a_gap_silent: assert property (p_gap_silent) else $error("gap not silent"); // R15

    property p_finish_done;
        @(posedge clk_in) disable iff (!rst_n_in) finish |=> done_q && !playing;
    endproperty
    a_finish_done: assert property (p_finish_done) else $error("finish flags wrong"); // R6

    c_oneshot_done: cover property (@(posedge clk_in) finish && mode_q == MODE_ONESHOT);
    c_melody_next:  cover property (@(posedge clk_in) do_load && playing && melody);
    c_stop_normal:  cover property (@(posedge clk_in) do_stop && mode_q == MODE_NORMAL);
    c_rest_play:    cover property (@(posedge clk_in) playing && rest_on);
    c_tie_load:     cover property (@(posedge clk_in) do_load && load_tie);
endmodule // tmg_core

// ===== tmg_buzzer_model.sv
`timescale 1ns/1ps
// Buzzer element on the two complementary pins; it only listens, counts tone edges and flags both pins high.
module tmg_buzzer_model (
    input  wire logic        clk_in,
    input  wire logic        rst_n_in,
    input  wire logic        buzzer_in,
    input  wire logic        buzzer_inverted_in,
    output logic      [15:0] edge_count_out,
    output logic             clash_out
);
    logic buzzer_q;

    // Both pins high would short the element; remember it for the bench.
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            clash_out <= 1'b0;
        end else if (buzzer_in && buzzer_inverted_in) begin
            clash_out <= 1'b1;
        end
    end

    // A rising edge of the tone counts once; the element sees nothing between edges.
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            buzzer_q       <= 1'b0;
            edge_count_out <= 16'h0000;
        end else begin
            buzzer_q <= buzzer_in;
            if (buzzer_in && !buzzer_q) begin
                edge_count_out <= edge_count_out + 16'h0001;
            end
        end
    end
endmodule // tmg_buzzer_model

// ===== tone_melody_generator_regs_tb_top.sv
`timescale 1ns/1ps
module tone_melody_generator_regs_tb_top;
    import tmg_pkg::*;
    logic        clk_in = 1'b0;
    logic        rst_n_in = 1'b0;
    logic [2:0]  addr_in = 3'h0;
    logic [15:0] wdata_in = 16'h0000;
    logic        wr_in = 1'b0;
    logic        wr_full_in = 1'b1;
    logic        rd_in = 1'b0;
    logic        debug_mode_in = 1'b0;
    logic [15:0] rdata_out;
    logic        buzzer_out;
    logic        buzzer_out_inverted_out;
    logic        irq_out;
    logic [15:0] edge_count;
    logic        clash;
    logic        rd_seen = 1'b0;
    logic [18:0] exp_q[$];
    logic [18:0] note;
    logic [15:0] dval;
    logic [15:0] rst_tab[8] = '{16'h0000, 16'h0000, 16'h0000, 16'h00ff, 16'h0002, 16'h0000, 16'h0000, 16'h0000};
    integer      seed = 32'hd0b1;
    int          err_total = 0;
    int          checks_done = 0;

    always #20 clk_in = ~clk_in;

    // The oscillator tick runs every cycle, so divide code 0 gives an op tick every 4 clocks.
    tmg_core uut (
        .clk_in                  (clk_in),
        .rst_n_in                (rst_n_in),
        .addr_in                 (addr_in),
        .wdata_in                (wdata_in),
        .wr_in                   (wr_in),
        .wr_full_in              (wr_full_in),
        .rd_in                   (rd_in),
        .rdata_out               (rdata_out),
        .debug_mode_in           (debug_mode_in),
        .int_osc_tick_in         (1'b1),
        .low_osc_tick_in         (1'b0),
        .high_osc_tick_in        (1'b0),
        .ext_clk_in              (1'b0),
        .buzzer_out              (buzzer_out),
        .buzzer_out_inverted_out (buzzer_out_inverted_out),
        .irq_out                 (irq_out)
    );

    tmg_buzzer_model buzzer (
        .clk_in             (clk_in),
        .rst_n_in           (rst_n_in),
        .buzzer_in          (buzzer_out),
        .buzzer_inverted_in (buzzer_out_inverted_out),
        .edge_count_out     (edge_count),
        .clash_out          (clash)
    );

    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        checks_done++;
        if (seen !== exp) begin
            err_total++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic final_report();
        if (err_total == 0 && checks_done > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    task automatic wr(input logic [2:0] a, input logic [15:0] d, input logic full = 1'b1);
        @(posedge clk_in);
        addr_in    <= a;
        wdata_in   <= d;
        wr_full_in <= full;
        wr_in      <= 1'b1;
        @(posedge clk_in);
        wr_in      <= 1'b0;
        wr_full_in <= 1'b1;
    endtask

    // The expected word is noted now and compared when the read data appear.
    task automatic rd(input logic [2:0] a, input logic [15:0] exp);
        @(posedge clk_in);
        addr_in <= a;
        rd_in   <= 1'b1;
        exp_q.push_back({a, exp});
        @(posedge clk_in);
        rd_in <= 1'b0;
    endtask

    always @(posedge clk_in) begin
        if (rd_seen) begin
            note = exp_q.pop_front();
            check($sformatf("register %0d", note[18:16]), rdata_out, note[15:0]);
        end
        rd_seen <= rd_in;
    end

    task automatic pins(input logic b, input logic bi);
        check("buzzer pin", {15'h0000, buzzer_out}, {15'h0000, b});
        check("inverted pin", {15'h0000, buzzer_out_inverted_out}, {15'h0000, bi});
    endtask

    initial begin
        // One-shot step is 512 op ticks of 4 clocks; the whole run, about 7000 clocks, stays below this 20000-clock limit.
        #(40 * 20000);
        err_total++;
        final_report();
    end

    initial begin
        repeat (12) @(posedge clk_in);
        rst_n_in <= 1'b1;
        for (int i = 0; i < 8; i++) begin
            rd(3'(i), rst_tab[i]);
        end
        wr(ADDR_CLK_CFG, 16'hffff);
        rd(ADDR_CLK_CFG, 16'h0173);
        wr(ADDR_CLK_CFG, 16'h0000);
        wr(ADDR_MODE, 16'hffff);
        rd(ADDR_MODE, 16'h0f07);
        wr(ADDR_MODE, 16'h0001);
        wr(ADDR_IRQ_EN, 16'hffff);
        rd(ADDR_IRQ_EN, 16'h0003);
        wr(ADDR_IRQ_EN, 16'h0000);
        wr(ADDR_CTL, 16'h0001);
        wr(ADDR_CLK_CFG, 16'h0003);
        rd(ADDR_CLK_CFG, 16'h0000);
        wr(ADDR_DATA, 16'h1234, 1'b0);
        rd(ADDR_DATA, 16'h00ff);
        rd(ADDR_FLAGS, 16'h0002);
        // One-shot with a random tone; debug mode freezes it a few op ticks after the start since debug_run is 0.
        dval = 16'($random(seed));
        dval = {2'b00, dval[13:8], 2'b00, dval[5:0]};
        wr(ADDR_DATA, dval);
        repeat (20) @(posedge clk_in);
        rd(ADDR_DATA, dval);
        rd(ADDR_FLAGS, 16'h0102);
        debug_mode_in <= 1'b1;
        repeat (2200) @(posedge clk_in);
        rd(ADDR_FLAGS, 16'h0102);
        debug_mode_in <= 1'b0;
        repeat (2200) @(posedge clk_in);
        rd(ADDR_FLAGS, 16'h0003);
        check("tone edges seen", {15'h0000, edge_count != 16'h0000}, 16'h0001);
        pins(1'b0, 1'b0);
        wr(ADDR_IRQ_EN, 16'h0001);
        repeat (3) @(posedge clk_in);
        check("irq done", {15'h0000, irq_out}, 16'h0001);
        wr(ADDR_FLAGS, 16'h0001);
        repeat (3) @(posedge clk_in);
        check("irq cleared", {15'h0000, irq_out}, 16'h0000);
        rd(ADDR_FLAGS, 16'h0002);
        wr(ADDR_IRQ_EN, 16'h0002);
        repeat (3) @(posedge clk_in);
        check("irq empty", {15'h0000, irq_out}, 16'h0001);
        wr(ADDR_IRQ_EN, 16'h0000);
        // Normal buzzer with normal drive plays until the stop request.
        wr(ADDR_MODE, 16'h0004);
        wr(ADDR_DATA, {8'h1f, 8'h07});
        repeat (100) @(posedge clk_in);
        for (int i = 0; i < 8; i++) begin
            repeat (3) @(posedge clk_in);
            check("complement", {15'h0000, buzzer_out ^ buzzer_out_inverted_out}, 16'h0001);
        end
        rd(ADDR_FLAGS, 16'h0102);
        wr(ADDR_CTL, 16'h0101);
        repeat (20) @(posedge clk_in);
        rd(ADDR_CTL, 16'h0001);
        rd(ADDR_FLAGS, 16'h0003);
        // A melody rest in direct drive keeps the tone low and the inverted pin high.
        wr(ADDR_FLAGS, 16'h0001);
        wr(ADDR_MODE, 16'h0002);
        wr(ADDR_DATA, 16'h4000);
        repeat (100) @(posedge clk_in);
        pins(1'b0, 1'b1);
        rd(ADDR_FLAGS, 16'h0102);
        repeat (2200) @(posedge clk_in);
        rd(ADDR_FLAGS, 16'h0003);
        pins(1'b0, 1'b0);
        check("pins both high", {15'h0000, clash}, 16'h0000);
        repeat (3) @(posedge clk_in);
        final_report();
    end
endmodule // tone_melody_generator_regs_tb_top
